// ### bench/uartms_bench.sv
// Bench: reset values, modem status, loopback, FIFO interrupts
`timescale 1ns/10ps
module uart_modem_status_fifo_irq_bench;
   import uartms_pkg::*;
   logic i_clk = 0, i_rst_n = 0, cyc = 0, we = 0, rxv = 0, ack, rts_n, dtr_n, irq_oe;
   logic rdy = 0, txv, irq, lpbk, tick;
   logic [7:0] txd, lcr_o, tk;
   logic [2:0] adr = 0, err = 0;
   logic [7:0] wd = 0, rxd = 0, v;
   logic [3:0] lvl = 4'hF, o, m;
   logic [31:0] rdat;
   logic [15:0] exp_q[$];
   logic cts_n, dsr_n, ri_n, dcd_n;
   int bad_count = 0, samples_checked = 0, cycles = 0, seed = 80248;
   // 250 MHz core clock
   always #2 i_clk = ~i_clk;
   uartms_modem_model i_uartms_modem_model (.i_clk(i_clk), .i_lvl(lvl), .o_cts_n(cts_n),
      .o_dsr_n(dsr_n), .o_ring_ind_n(ri_n), .o_carrier_detect_n(dcd_n));
   uartms_core i_uartms_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat({24'h00_0000, wd}),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_err(err),
      .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(rdy), .i_tx_idle(1'b1),
      .o_baud_tick(tick), .o_line_ctrl(lcr_o), .o_loopback(lpbk), .i_cts_n(cts_n),
      .i_dsr_n(dsr_n), .i_ring_ind_n(ri_n), .i_carrier_detect_n(dcd_n), .o_rts_n(rts_n),
      .o_dtr_n(dtr_n), .o_irq(irq), .o_irq_oe(irq_oe));
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // Classic cycle: hold until ack is sampled, then release for a cycle
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge i_clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
      exp_q.push_back({k, e & k});
      bus(1'b0, a, 8'h00);
   endtask : rd
   task automatic rx(input logic [2:0] e);
      rxd <= 8'($random(seed));
      err <= e;
      rxv <= 1'b1;
      @(posedge i_clk);
      rxv <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask : rx
   // Oldest note against each read answer; we is still held at ack
   always @(posedge i_clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         check(rdat[7:0] & exp_q[0][15:8], exp_q[0][7:0]);
         void'(exp_q.pop_front());
      end
   end
   // Hang guard, well above the expected run
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   initial begin
      lvl <= 4'($random(seed));
      repeat (RESET_HOLD_CYC) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      o = lvl;
      check({5'h00, rts_n, dtr_n, irq_oe}, 8'h06);
      check(lcr_o, 8'h00);
      rd(REG_IDENT, IIR_RESET, 8'hFF);
      rd(REG_LINE_STATUS, LSR_RESET, 8'hFF);
      rd(REG_MODEM_STATUS, {~o, 4'h0}, 8'hFF);
      // Random line changes, each read twice so flags must clear
      repeat (8) begin
         v = 8'($random(seed));
         lvl <= v[3:0];
         repeat (6) @(posedge i_clk);
         m = o ^ v[3:0];
         rd(REG_MODEM_STATUS, {~v[3:0], m[3], ~o[2] & v[2], m[1:0]}, 8'hFF);
         rd(REG_MODEM_STATUS, {~v[3:0], 4'h0}, 8'hFF);
         o = v[3:0];
      end
      v = 8'($random(seed)) | 8'h10;
      bus(1'b1, REG_MODEM_CTRL, v & 8'h1F);
      rd(REG_MODEM_STATUS, {v[3], v[2], v[0], v[1], 4'h0}, 8'hF0);
      // Loopback keeps the request and ready lines inactive
      check({6'h00, lpbk, rts_n & dtr_n}, 8'h03);
      bus(1'b1, REG_MODEM_CTRL, 8'h00);
      bus(1'b1, REG_IDENT, 8'h01);
      rd(REG_LINE_STATUS, 8'h60, 8'hFF);
      rx(3'h0);
      rd(REG_LINE_STATUS, 8'h01, 8'h01);
      rd(REG_IDENT, 8'hC1, 8'hFF);
      rd(REG_DATA, rxd, 8'hFF);
      bus(1'b1, REG_IRQ_EN, 8'h05);
      rx(3'h0);
      rd(REG_IDENT, 8'hC4, 8'hFF);
      rd(REG_DATA, rxd, 8'hFF);
      rd(REG_IDENT, 8'hC1, 8'hFF);
      rx(3'h1);
      rd(REG_IDENT, 8'hC6, 8'hFF);
      rd(REG_LINE_STATUS, 8'hE5, 8'hFF);
      rd(REG_IDENT, 8'hC4, 8'hFF);
      rd(REG_DATA, rxd, 8'hFF);
      bus(1'b1, REG_IRQ_EN, 8'h07);
      rd(REG_IDENT, 8'hC2, 8'hFF);
      rd(REG_IDENT, 8'hC1, 8'hFF);
      // Trigger 4, irq pin enabled, empty interrupt raised again by re-enabling
      bus(1'b1, REG_IDENT, 8'h41);
      bus(1'b1, REG_MODEM_CTRL, 8'h08);
      bus(1'b1, REG_IRQ_EN, 8'h05);
      bus(1'b1, REG_IRQ_EN, 8'h07);
      check({6'h00, irq, irq_oe}, 8'h03);
      bus(1'b1, REG_DATA, 8'hA5);
      check({6'h00, irq, txv}, 8'h01);
      check(txd, 8'hA5);
      rx(3'h0);
      rd(REG_IDENT, 8'hC1, 8'hFF);
      // Lone byte leaves; empty must wait about one character
      rdy <= 1'b1;
      @(posedge i_clk);
      rdy <= 1'b0;
      rd(REG_LINE_STATUS, 8'h01, 8'h61);
      // Any 3250 cycles hold exactly 24 reference ticks
      tk = 8'h00;
      repeat (3250) begin
         @(posedge i_clk);
         tk = tk + {7'h00, tick};
      end
      check(tk, 8'h18);
      repeat (9000) @(posedge i_clk);
      check({7'h00, irq}, 8'h01);
      rd(REG_IDENT, 8'hC2, 8'hFF);
      // Untouched byte below trigger times out after four characters
      repeat (41000) @(posedge i_clk);
      rd(REG_IDENT, 8'hCC, 8'hFF);
      rd(REG_DATA, rxd, 8'hFF);
      rd(REG_IDENT, 8'hC1, 8'hFF);
      repeat (2) @(posedge i_clk);
      tally_and_finish();
   end
endmodule : uart_modem_status_fifo_irq_bench

// ### bench/uartms_modem_model.sv
// Modem model driving the active-low control lines
`timescale 1ns/10ps
module uartms_modem_model (
   input wire logic i_clk,
   input wire logic [3:0] i_lvl,
   output logic o_cts_n,
   output logic o_dsr_n,
   output logic o_ring_ind_n,
   output logic o_carrier_detect_n
);
   // Idle modem: all lines inactive high
   initial {o_carrier_detect_n, o_ring_ind_n, o_dsr_n, o_cts_n} = 4'hF;
   // Lines follow one cycle late, like a slow modem
   always @(posedge i_clk) begin
      {o_carrier_detect_n, o_ring_ind_n, o_dsr_n, o_cts_n} <= i_lvl;
   end
endmodule : uartms_modem_model

// ### hw/uartms_core.sv
// Serial channel registers, FIFOs, interrupt identification and modem status
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
module uartms_core #(
   parameter int unsigned DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [4:2] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic [2:0] i_rx_err,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   input wire logic i_tx_idle,
   output logic o_baud_tick,
   output logic [7:0] o_line_ctrl,
   output logic o_loopback,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ring_ind_n,
   input wire logic i_carrier_detect_n,
   output logic o_rts_n,
   output logic o_dtr_n,
   output logic o_irq,
   output logic o_irq_oe
);
   import uartms_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic ack;
      logic [7:0] rdat;
      logic [7:0] irq_enable_reg;
      logic [7:0] line_ctrl_reg;
      logic [4:0] modem_ctrl_reg;
      logic fifo_en;
      logic [1:0] trig;
      logic [7:0] scratch;
      logic [7:0] dll;
      logic [7:0] divisor_high;
      logic [12:0] ref_acc;
      logic [15:0] div_cnt;
      logic [DEPTH-1:0][7:0] rxq;
      logic [AW-1:0] rx_wp;
      logic [AW-1:0] rx_rp;
      logic [AW:0] rx_cnt;
      logic [DEPTH-1:0][7:0] txq;
      logic [AW-1:0] tx_wp;
      logic [AW-1:0] tx_rp;
      logic [AW:0] tx_cnt;
      logic [4:1] err;
      logic fifo_err;
      logic [9:0] to_cnt;
      logic to_flag;
      uartms_txe_e txe;
      logic [7:0] txe_cnt;
      logic two_seen;
      logic tx_holding_empty_ip;
   } uartms_state_s;

   uartms_state_s s_r, s_nxt;
   logic [7:0] modem_line_status;
   logic msr_rd;
   logic req, wr, rd, dlab;
   logic ref_tick, tick;
   logic rx_push, rx_pop, rx_over, tx_push, tx_pop;
   logic [AW:0] rx_cap;
   logic [9:0] to_limit;
   logic [7:0] txe_delay;
   logic line_ip, rx_ip, to_ip, tx_ip, mdm_ip, pending;
   logic [2:0] iid;
   logic [7:0] iir_val, lsr_val;
   // FIFO mode flip seen on the bus, for the assertions that exempt it
   logic fifo_toggle_w;
   assign fifo_toggle_w = wr && i_wb_adr == REG_IDENT && (i_wb_dat[FCR_EN] != s_r.fifo_en);

   // Receive trigger level selected by two control bits
   function automatic logic [AW:0] trig_lvl(input logic [1:0] t);
      case (t)
         2'h0: trig_lvl = (AW+1)'(1);
         2'h1: trig_lvl = (AW+1)'(4);
         2'h2: trig_lvl = (AW+1)'(8);
         default: trig_lvl = (AW+1)'(DEPTH - 2);
      endcase
   endfunction : trig_lvl

   uartms_modem u_modem (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_loop(s_r.modem_ctrl_reg[MCR_LOOP]),
      .i_mcr(s_r.modem_ctrl_reg),
      .i_cts_n(i_cts_n),
      .i_dsr_n(i_dsr_n),
      .i_ring_ind_n(i_ring_ind_n),
      .i_carrier_detect_n(i_carrier_detect_n),
      .i_clear(msr_rd),
      .o_modem_line_status(modem_line_status)
   );

   // Bus decode; one wait cycle, ack a single cycle per request
   assign req = i_wb_cyc & i_wb_stb & ~s_r.ack;
   assign wr = req & i_wb_we & i_wb_sel[0];
   assign rd = req & ~i_wb_we;
   assign dlab = s_r.line_ctrl_reg[LCR_DLAB];
   assign msr_rd = rd & (i_wb_adr == REG_MODEM_STATUS);

   // Handshakes with the shift logic
   assign rx_cap = s_r.fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
   assign rx_over = i_rx_valid & (s_r.rx_cnt >= rx_cap);
   assign rx_push = i_rx_valid & ~rx_over;
   assign rx_pop = rd & (i_wb_adr == REG_DATA) & ~dlab & (s_r.rx_cnt != '0);
   assign tx_push = wr & (i_wb_adr == REG_DATA) & ~dlab &
      (s_r.tx_cnt < (s_r.fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1)));
   assign o_tx_valid = (s_r.tx_cnt != '0);
   assign tx_pop = o_tx_valid & i_tx_ready;

   // Frame-dependent counts, in sample ticks
   assign to_limit = 10'(char_bits(s_r.line_ctrl_reg)) * 10'(SAMPLES_PER_BIT * TIMEOUT_CHARS);
   assign txe_delay = 8'(char_bits(s_r.line_ctrl_reg) - 4'h1) * 8'(SAMPLES_PER_BIT);

   // Interrupt sources and their fixed priority
   assign line_ip = s_r.irq_enable_reg[IER_LINE] & (|s_r.err);
   assign rx_ip = s_r.irq_enable_reg[IER_RX] & (s_r.fifo_en ?
      (s_r.rx_cnt >= trig_lvl(s_r.trig)) : (s_r.rx_cnt != '0));
   assign to_ip = s_r.irq_enable_reg[IER_RX] & s_r.fifo_en & s_r.to_flag;
   assign tx_ip = s_r.irq_enable_reg[IER_TX] & s_r.tx_holding_empty_ip;
   assign mdm_ip = s_r.irq_enable_reg[IER_MODEM] & (|modem_line_status[3:0]);
   assign pending = line_ip | rx_ip | to_ip | tx_ip | mdm_ip;

   // Highest source wins; time-out ranks just below data, FIFO empty with holding
   always_comb begin
      if (line_ip) begin
         iid = IID_LINE;
      end else if (rx_ip) begin
         iid = IID_RXDATA;
      end else if (to_ip) begin
         iid = IID_TIMEOUT;
      end else if (tx_ip) begin
         iid = IID_TX_HOLDING_EMPTY;
      end else begin
         iid = IID_MODEM;
      end
   end

   assign iir_val = {s_r.fifo_en, s_r.fifo_en, 2'h0, iid, ~pending};
   assign lsr_val = {s_r.fifo_en & s_r.fifo_err,
      (s_r.txe == TXE_EMPTY) & (s_r.tx_cnt == '0) & i_tx_idle,
      s_r.txe == TXE_EMPTY, s_r.err, s_r.rx_cnt != '0};

   // Whole next state of the block
   always_comb begin
      logic [12:0] acc;
      logic [15:0] divisor;
      logic [7:0] wdat;
      logic fifo_toggle;
      acc = s_r.ref_acc + REF_STEP;
      divisor = {s_r.divisor_high, s_r.dll};
      wdat = i_wb_dat[7:0];
      fifo_toggle = 1'b0;
      s_nxt = s_r;
      s_nxt.ack = req;
      // Fractional reference: 24 of every 3250 core cycles
      ref_tick = (acc >= REF_MOD);
      s_nxt.ref_acc = ref_tick ? (acc - REF_MOD) : acc;
      // Sample tick from the divisor; zero divisor counts as one
      tick = 1'b0;
      if (ref_tick) begin
         if ((s_r.div_cnt + 16'h0001) >= divisor) begin
            s_nxt.div_cnt = 16'h0000;
            tick = 1'b1;
         end else begin
            s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
         end
      end
      // Register reads, captured at the answering edge
      if (rd) begin
         case (i_wb_adr)
            REG_DATA: s_nxt.rdat = dlab ? s_r.dll : s_r.rxq[s_r.rx_rp];
            REG_IRQ_EN: s_nxt.rdat = dlab ? s_r.divisor_high : {4'h0, s_r.irq_enable_reg[3:0]};
            REG_IDENT: s_nxt.rdat = iir_val;
            REG_LINE_CTRL: s_nxt.rdat = s_r.line_ctrl_reg;
            REG_MODEM_CTRL: s_nxt.rdat = {3'h0, s_r.modem_ctrl_reg};
            REG_LINE_STATUS: s_nxt.rdat = lsr_val;
            REG_MODEM_STATUS: s_nxt.rdat = modem_line_status;
            default: s_nxt.rdat = s_r.scratch;
         endcase
      end
      // Read side effects: errors clear on status read
      if (rd && i_wb_adr == REG_LINE_STATUS) begin
         s_nxt.err = 4'h0;
         s_nxt.fifo_err = 1'b0;
      end
      if (rd && i_wb_adr == REG_IDENT && iid == IID_TX_HOLDING_EMPTY && pending) begin
         s_nxt.tx_holding_empty_ip = 1'b0;
      end
      // Register writes
      if (wr) begin
         case (i_wb_adr)
            REG_DATA: begin
               if (dlab) begin
                  s_nxt.dll = wdat;
               end
            end
            REG_IRQ_EN: begin
               if (dlab) begin
                  s_nxt.divisor_high = wdat;
               end else begin
                  s_nxt.irq_enable_reg = {4'h0, wdat[3:0]};
                  // Enabling on an already empty holding register interrupts
                  if (wdat[IER_TX] && !s_r.irq_enable_reg[IER_TX] && s_r.txe == TXE_EMPTY) begin
                     s_nxt.tx_holding_empty_ip = 1'b1;
                  end
               end
            end
            REG_IDENT: begin
               fifo_toggle = (wdat[FCR_EN] != s_r.fifo_en);
               s_nxt.fifo_en = wdat[FCR_EN];
               s_nxt.trig = wdat[7:6];
               if (wdat[FCR_RX_CLR] || fifo_toggle) begin
                  s_nxt.rx_wp = '0;
                  s_nxt.rx_rp = '0;
                  s_nxt.rx_cnt = '0;
               end
               if (wdat[FCR_TX_CLR] || fifo_toggle) begin
                  s_nxt.tx_wp = '0;
                  s_nxt.tx_rp = '0;
                  s_nxt.tx_cnt = '0;
               end
            end
            REG_LINE_CTRL: s_nxt.line_ctrl_reg = wdat;
            REG_MODEM_CTRL: s_nxt.modem_ctrl_reg = wdat[4:0];
            REG_SCRATCH: s_nxt.scratch = wdat;
            default: ;
         endcase
      end
      // Receive FIFO; overrun keeps the stored data
      if (!(fifo_toggle || (wr && i_wb_adr == REG_IDENT && wdat[FCR_RX_CLR]))) begin
         if (rx_push) begin
            s_nxt.rxq[s_r.rx_wp] = i_rx_data;
            s_nxt.rx_wp = s_r.rx_wp + 1'b1;
         end
         if (rx_pop) begin
            s_nxt.rx_rp = s_r.rx_rp + 1'b1;
         end
         s_nxt.rx_cnt = s_r.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      end
      // Error flags set after the clear, so a new error is kept
      if (rx_over) begin
         s_nxt.err[1] = 1'b1;
      end
      if (rx_push) begin
         s_nxt.err[4:2] = s_nxt.err[4:2] | i_rx_err;
         s_nxt.fifo_err = s_nxt.fifo_err | (|i_rx_err);
      end
      // Character time-out, counted in sample ticks
      if (rx_push || rx_pop || s_nxt.rx_cnt == '0) begin
         s_nxt.to_cnt = 10'h000;
         s_nxt.to_flag = 1'b0;
      end else if (s_r.fifo_en && tick && !s_r.to_flag) begin
         s_nxt.to_cnt = s_r.to_cnt + 10'h001;
         if ((s_r.to_cnt + 10'h001) >= to_limit) begin
            s_nxt.to_flag = 1'b1;
         end
      end
      // Transmit FIFO
      if (!(fifo_toggle || (wr && i_wb_adr == REG_IDENT && wdat[FCR_TX_CLR]))) begin
         if (tx_push) begin
            s_nxt.txq[s_r.tx_wp] = wdat;
            s_nxt.tx_wp = s_r.tx_wp + 1'b1;
         end
         if (tx_pop) begin
            s_nxt.tx_rp = s_r.tx_rp + 1'b1;
         end
         s_nxt.tx_cnt = s_r.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
      if (s_nxt.tx_cnt >= (AW+1)'(2)) begin
         s_nxt.two_seen = 1'b1;
      end
      // Empty indication; in FIFO mode a lone byte earns a delayed empty
      case (s_r.txe)
         TXE_EMPTY: begin
            s_nxt.two_seen = (s_nxt.tx_cnt >= (AW+1)'(2));
            if (s_nxt.tx_cnt != '0) begin
               s_nxt.txe = TXE_BUSY;
            end
         end
         TXE_BUSY: begin
            if (s_nxt.tx_cnt == '0) begin
               if (s_r.two_seen || !s_r.fifo_en) begin
                  s_nxt.txe = TXE_EMPTY;
                  s_nxt.tx_holding_empty_ip = s_r.irq_enable_reg[IER_TX];
               end else begin
                  s_nxt.txe = TXE_DELAY;
                  s_nxt.txe_cnt = txe_delay;
               end
            end
         end
         TXE_DELAY: begin
            if (s_nxt.tx_cnt != '0) begin
               s_nxt.txe = TXE_BUSY;
            end else if (s_r.txe_cnt == 8'h00) begin
               s_nxt.txe = TXE_EMPTY;
               s_nxt.tx_holding_empty_ip = s_r.irq_enable_reg[IER_TX];
            end else if (tick) begin
               s_nxt.txe_cnt = s_r.txe_cnt - 8'h01;
            end
         end
         default: s_nxt.txe = TXE_EMPTY;
      endcase
      // Toggling FIFO mode shows empty at once
      if (fifo_toggle) begin
         s_nxt.txe = TXE_EMPTY;
         s_nxt.tx_holding_empty_ip = s_nxt.irq_enable_reg[IER_TX];
      end
      // A holding write withdraws the empty interrupt
      if (tx_push) begin
         s_nxt.tx_holding_empty_ip = 1'b0;
      end
   end

   // Synchronous reset clears controls and the baud counters
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs; modem lines go inactive high in loopback
   assign o_wb_ack = s_r.ack;
   assign o_wb_dat = {24'h00_0000, s_r.rdat};
   assign o_tx_data = s_r.txq[s_r.tx_rp];
   assign o_baud_tick = tick;
   assign o_line_ctrl = s_r.line_ctrl_reg;
   assign o_loopback = s_r.modem_ctrl_reg[MCR_LOOP];
   assign o_rts_n = ~s_r.modem_ctrl_reg[MCR_RTS] | s_r.modem_ctrl_reg[MCR_LOOP];
   assign o_dtr_n = ~s_r.modem_ctrl_reg[MCR_DTR] | s_r.modem_ctrl_reg[MCR_LOOP];
   assign o_irq = pending & s_r.modem_ctrl_reg[MCR_USER_B];
   assign o_irq_oe = s_r.modem_ctrl_reg[MCR_USER_B] & ~s_r.modem_ctrl_reg[MCR_LOOP];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_bus_ack;
      req |=> o_wb_ack ##1 !o_wb_ack;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");
   property p_iir_idle;
      (s_r.irq_enable_reg == 8'h00 && !s_r.fifo_en) |-> iir_val == IIR_RESET;
   endproperty
   a_iir_idle: assert property (p_iir_idle) else $error("idle identification wrong");
   property p_lsr_idle;
      (s_r.rx_cnt == '0 && s_r.tx_cnt == '0 && s_r.txe == TXE_EMPTY &&
       s_r.err == 4'h0 && !s_r.fifo_err && i_tx_idle) |-> lsr_val == LSR_RESET;
   endproperty
   a_lsr_idle: assert property (p_lsr_idle) else $error("idle line status wrong");
   property p_trig;
      (s_r.fifo_en && s_r.rx_cnt < trig_lvl(s_r.trig)) |-> !rx_ip;
   endproperty
   a_trig: assert property (p_trig) else $error("data interrupt below trigger");
   property p_prio;
      (line_ip && (rx_ip || to_ip)) |-> iid == IID_LINE;
   endproperty
   a_prio: assert property (p_prio) else $error("line status not first");
   property p_to_restart;
      (i_rx_valid && !rx_over && !fifo_toggle_w) |=> s_r.to_cnt == 10'h000 && !s_r.to_flag;
   endproperty
   a_to_restart: assert property (p_to_restart) else $error("time-out not restarted");
   property p_to_hold;
      s_r.to_flag |-> s_r.fifo_en && s_r.rx_cnt != '0 && s_r.to_cnt >= to_limit;
   endproperty
   a_to_hold: assert property (p_to_hold) else $error("time-out without cause");
   property p_thr_clear;
      tx_push |=> !s_r.tx_holding_empty_ip;
   endproperty
   a_thr_clear: assert property (p_thr_clear) else $error("empty interrupt not cleared");
   property p_lone_delay;
      (s_r.txe == TXE_BUSY && s_nxt.tx_cnt == '0 && !s_r.two_seen && s_r.fifo_en &&
       !fifo_toggle_w) |=> s_r.txe == TXE_DELAY ##1 s_r.txe != TXE_EMPTY;
   endproperty
   a_lone_delay: assert property (p_lone_delay) else $error("lone byte empty not delayed");
   property p_polled;
      (s_r.fifo_en && !s_r.irq_enable_reg[IER_RX]) |-> iid != IID_RXDATA && iid != IID_TIMEOUT &&
         lsr_val[0] == (s_r.rx_cnt != '0);
   endproperty
   a_polled: assert property (p_polled) else $error("polled mode indication wrong");
   c_timeout: cover property (to_ip);
   c_lone_delay: cover property (s_r.txe == TXE_DELAY ##1 s_r.txe == TXE_EMPTY);
   c_trig_full: cover property (rx_ip && s_r.fifo_en && s_r.trig == 2'h3);
endmodule : uartms_core

// ### hw/uartms_modem.sv
// Modem status register: live line levels and change flags
`timescale 1ns/10ps
module uartms_modem (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_loop,
   input wire logic [4:0] i_mcr,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_ring_ind_n,
   input wire logic i_carrier_detect_n,
   input wire logic i_clear,
   output logic [7:0] o_modem_line_status
);
   import uartms_pkg::*;

   typedef struct packed {
      logic primed;
      logic [3:0] prev;
      logic [3:0] delta;
   } uartms_msr_s;

   uartms_msr_s s_r, s_nxt;
   logic [3:0] src;

   // Live levels: pins, or modem control bits in loopback
   always_comb begin
      if (i_loop) begin
         src = {i_mcr[MCR_USER_B], i_mcr[MCR_USER_A], i_mcr[MCR_DTR], i_mcr[MCR_RTS]};
      end else begin
         src = {~i_carrier_detect_n, ~i_ring_ind_n, ~i_dsr_n, ~i_cts_n};
      end
   end

   // Change flags; the first cycle after reset only primes, so no false deltas
   always_comb begin
      s_nxt = s_r;
      s_nxt.primed = 1'b1;
      s_nxt.prev = src;
      if (i_clear) begin
         s_nxt.delta = 4'h0;
      end
      // A change in the read cycle still sets its flag
      if (s_r.primed) begin
         s_nxt.delta[0] = s_nxt.delta[0] | (src[0] ^ s_r.prev[0]);
         s_nxt.delta[1] = s_nxt.delta[1] | (src[1] ^ s_r.prev[1]);
         s_nxt.delta[3] = s_nxt.delta[3] | (src[3] ^ s_r.prev[3]);
         s_nxt.delta[2] = s_nxt.delta[2] | (s_r.prev[2] & ~src[2]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_modem_line_status = {src, s_r.delta};

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_msr_live;
      o_modem_line_status[7:4] == (i_loop ?
         {i_mcr[MCR_USER_B], i_mcr[MCR_USER_A], i_mcr[MCR_DTR], i_mcr[MCR_RTS]} :
         {~i_carrier_detect_n, ~i_ring_ind_n, ~i_dsr_n, ~i_cts_n});
   endproperty
   a_msr_live: assert property (p_msr_live) else $error("modem status live bits wrong");
   property p_delta_set;
      (s_r.primed && (src[0] != s_r.prev[0])) |=> o_modem_line_status[0];
   endproperty
   a_delta_set: assert property (p_delta_set) else $error("cts change not flagged");
   property p_ring_trail;
      (s_r.primed && s_r.prev[2] && !src[2]) |=> o_modem_line_status[2];
   endproperty
   a_ring_trail: assert property (p_ring_trail) else $error("ring trailing edge missed");
   property p_ring_lead;
      (!s_r.prev[2] && src[2] && !o_modem_line_status[2]) |=> !o_modem_line_status[2];
   endproperty
   a_ring_lead: assert property (p_ring_lead) else $error("ring leading edge flagged");
   property p_read_clear;
      (i_clear && src == s_r.prev) |=> o_modem_line_status[3:0] == 4'h0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear deltas");
   c_ring_trail: cover property (s_r.primed && s_r.prev[2] && !src[2]);
endmodule : uartms_modem

// ### hw/uartms_pkg.sv
// Shared constants, types and helpers of the modem status and FIFO interrupt block
package uartms_pkg;
   // Core clock and serial reference (24 MHz divided by 13)
   localparam int unsigned CLK_FREQ_MHZ = 250;
   localparam int unsigned REF_NUM_MHZ = 24;
   localparam int unsigned REF_DIV = 13;
   localparam logic [12:0] REF_STEP = 13'(REF_NUM_MHZ);
   localparam logic [12:0] REF_MOD = 13'(CLK_FREQ_MHZ * REF_DIV);
   // Reset hold needed from the outside, rounded up to whole cycles
   localparam int unsigned RESET_HOLD_NS = 500;
   localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;
   // Character timing
   localparam int unsigned SAMPLES_PER_BIT = 16;
   localparam int unsigned TIMEOUT_CHARS = 4;
   // Register indices; byte address is four times the index
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_IRQ_EN = 3'h1;
   localparam logic [2:0] REG_IDENT = 3'h2;
   localparam logic [2:0] REG_LINE_CTRL = 3'h3;
   localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
   localparam logic [2:0] REG_LINE_STATUS = 3'h5;
   localparam logic [2:0] REG_MODEM_STATUS = 3'h6;
   localparam logic [2:0] REG_SCRATCH = 3'h7;
   // Modem control bits
   localparam int unsigned MCR_DTR = 0;
   localparam int unsigned MCR_RTS = 1;
   localparam int unsigned MCR_USER_A = 2;
   localparam int unsigned MCR_USER_B = 3;
   localparam int unsigned MCR_LOOP = 4;
   // Interrupt enable bits
   localparam int unsigned IER_RX = 0;
   localparam int unsigned IER_TX = 1;
   localparam int unsigned IER_LINE = 2;
   localparam int unsigned IER_MODEM = 3;
   // FIFO control and line control bits
   localparam int unsigned FCR_EN = 0;
   localparam int unsigned FCR_RX_CLR = 1;
   localparam int unsigned FCR_TX_CLR = 2;
   localparam int unsigned LCR_DLAB = 7;
   // Interrupt source codes, bits 3:1 of the identification byte
   localparam logic [2:0] IID_LINE = 3'h3;
   localparam logic [2:0] IID_RXDATA = 3'h2;
   localparam logic [2:0] IID_TIMEOUT = 3'h6;
   localparam logic [2:0] IID_TX_HOLDING_EMPTY = 3'h1;
   localparam logic [2:0] IID_MODEM = 3'h0;
   // Reset readings
   localparam logic [7:0] IIR_RESET = 8'h01;
   localparam logic [7:0] LSR_RESET = 8'h60;
   // Transmit-empty indication states, Gray along empty, busy, delay
   typedef enum logic [1:0] {
      TXE_EMPTY = 2'h0,
      TXE_BUSY = 2'h1,
      TXE_DELAY = 2'h3
   } uartms_txe_e;

   // Bits per character frame: data, parity and stop; the start bit is not counted
   function automatic logic [3:0] char_bits(input logic [7:0] line_ctrl_reg);
      char_bits = 4'h6 + {2'h0, line_ctrl_reg[1:0]} + {3'h0, line_ctrl_reg[3]} + {3'h0, line_ctrl_reg[2]};
   endfunction : char_bits
endpackage : uartms_pkg
